/* File: hw/crc_ctrl.sv */
// Comparator reference control register bank with AXI4-Lite slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
module crc_ctrl #(
    parameter int SETTLE_CYCLES = crc_pkg::FIXED_SETTLE_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmp_one_result,
    input  wire logic        cmp_two_result,
    input  wire logic        fast_internal_oscillator,
    input  wire logic        voltage_detector,
    input  wire logic        brownout_reset,
    input  wire logic        adc_fixed_ref_chan,
    input  wire logic        ref_pin_port_in,
    input  wire logic        ref_pin_tris,
    output logic             ladder_power,
    output logic [4:0]       ladder_tap,
    output logic             ladder_low_range,
    output logic             ladder_source_sel,
    output logic             ladder_bottom_ground,
    output logic             ladder_pin_output_enable,
    output logic             ref_pin_digital_out_en,
    output logic             ref_pin_digital_in_en,
    output logic             ref_pin_port_read,
    output logic             fixed_ref_power,
    output logic             cmp_one_internal_ref_sel,
    output logic             cmp_two_internal_ref_sel,
    output logic             cmp_one_noninv_internal,
    output logic             cmp_two_noninv_internal
);
    import crc_pkg::*;

    // Control registers
    logic [1:0]  refsel_r;
    logic [7:0]  ladder_r;
    logic        fixed_en_r;
    logic [1:0]  noninv_r;
    logic        stable_r;
    logic [31:0] settle_cnt_r;
    logic [1:0]  cmp_meta_r;
    logic [1:0]  cmp_sync_r;
    logic        pin_meta_r;
    logic        pin_sync_r;
    // Write channel holding
    logic        aw_full_r;
    logic [11:0] aw_addr_r;
    logic        w_full_r;
    logic [31:0] w_data_r;
    logic        w_strb0_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    // Address decode as a function, shared by read and write paths
    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == OFF_MIRROR_REFSEL) || (a == OFF_LADDER_CTRL) ||
                      (a == OFF_FIXED_CTRL) || (a == OFF_CMP_INPUT_SEL);
    endfunction

    // Handshake decode
    wire         do_write  = aw_full_r && w_full_r && !bvalid_r;
    wire         wr_lane0  = do_write && w_strb0_r;
    wire         wr_mirror = wr_lane0 && (aw_addr_r == OFF_MIRROR_REFSEL);
    wire         wr_ladder = wr_lane0 && (aw_addr_r == OFF_LADDER_CTRL);
    wire         wr_fixed  = wr_lane0 && (aw_addr_r == OFF_FIXED_CTRL);
    wire         wr_noninv = wr_lane0 && (aw_addr_r == OFF_CMP_INPUT_SEL);
    wire         do_read   = s_axi_arvalid && !rvalid_r;
    wire         fixed_on  = fixed_en_r || fast_internal_oscillator || voltage_detector ||
                             brownout_reset || adc_fixed_ref_chan;

    // Register read images; unimplemented bits read as zero
    wire [7:0]   img_mirror = {cmp_sync_r[0], cmp_sync_r[1], refsel_r, 4'h0};
    wire [7:0]   img_fixed  = {fixed_en_r, stable_r, 6'h00};
    wire [7:0]   img_noninv = {6'h00, noninv_r};
    wire [7:0]   rd_img     = (s_axi_araddr == OFF_MIRROR_REFSEL) ? img_mirror :
                              (s_axi_araddr == OFF_LADDER_CTRL)   ? ladder_r   :
                              (s_axi_araddr == OFF_FIXED_CTRL)    ? img_fixed  :
                              (s_axi_araddr == OFF_CMP_INPUT_SEL) ? img_noninv : 8'h00;

    // Ready signals accept one of each while the slot is empty
    assign s_axi_awready = !aw_full_r;
    assign s_axi_wready  = !w_full_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Write address and data capture in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_full_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_full_r) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_r) begin
                w_full_r  <= 1'b1;
                w_data_r  <= s_axi_wdata;
                w_strb0_r <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_full_r  <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read response, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h00_0000, rd_img};
            rresp_r  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Control registers; only the device reset clears them, not sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refsel_r   <= RST_MIRROR_REFSEL[BIT_CMP_ONE_RSEL:BIT_CMP_TWO_RSEL];
            ladder_r   <= RST_LADDER_CTRL;
            fixed_en_r <= RST_FIXED_CTRL[BIT_FIXED_EN];
            noninv_r   <= RST_CMP_INPUT_SEL;
        end else begin
            if (wr_mirror) begin
                refsel_r <= w_data_r[BIT_CMP_ONE_RSEL:BIT_CMP_TWO_RSEL];
            end
            if (wr_ladder) begin
                ladder_r <= w_data_r[7:0];
            end
            if (wr_fixed) begin
                fixed_en_r <= w_data_r[BIT_FIXED_EN];      // stable bit is read-only
            end
            if (wr_noninv) begin
                noninv_r <= w_data_r[1:0];
            end
        end
    end

    // Two-stage synchronisers for comparator results and the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_meta_r <= 2'h0;
            cmp_sync_r <= 2'h0;
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= {cmp_two_result, cmp_one_result};
            cmp_sync_r <= cmp_meta_r;
            pin_meta_r <= ref_pin_port_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // Settling counter: stable once the reference has run long enough
    always_ff @(posedge aclk) begin
        if (!aresetn || !fixed_on) begin
            settle_cnt_r <= 32'h0000_0000;
            stable_r     <= 1'b0;
        end else if (settle_cnt_r >= 32'(SETTLE_CYCLES - 1)) begin
            stable_r     <= 1'b1;
        end else begin
            settle_cnt_r <= settle_cnt_r + 32'h0000_0001;
        end
    end

    // Ladder outputs
    wire         low_range = ladder_r[BIT_LADDER_RANGE];
    wire [4:0]   level5    = {1'b0, ladder_r[3:0]};
    assign ladder_power         = ladder_r[BIT_LADDER_EN];
    assign ladder_low_range     = low_range;
    assign ladder_tap           = low_range ? level5 : (level5 + HIGH_RANGE_OFFSET);
    assign ladder_source_sel    = ladder_r[BIT_LADDER_SRC];
    assign ladder_bottom_ground = !ladder_r[BIT_LADDER_SRC];

    // Reference pin override
    wire         pin_ref = ladder_r[BIT_LADDER_OE];
    assign ladder_pin_output_enable = pin_ref;
    assign ref_pin_digital_out_en   = !pin_ref && !ref_pin_tris;
    assign ref_pin_digital_in_en    = !pin_ref;
    assign ref_pin_port_read        = pin_ref ? 1'b0 : pin_sync_r;

    // Fixed reference and comparator routing
    assign fixed_ref_power          = fixed_on;
    assign cmp_one_internal_ref_sel = refsel_r[1];
    assign cmp_two_internal_ref_sel = refsel_r[0];
    assign cmp_one_noninv_internal  = noninv_r[BIT_NONINV_ONE];
    assign cmp_two_noninv_internal  = noninv_r[BIT_NONINV_TWO];
endmodule

/* File: hw/crc_pkg.sv */
// Package: register map, field positions, reset values and timing for the reference control block
// How it works
// - Status top bits mirror both comparator outputs
// - Select bit 5 picks ladder or fixed for one
// - Select bit 4 picks ladder or fixed for two
// - Status low four bits read zero, ignore writes
// - Divider power follows ladder enable only
// - Low range tap equals level of 24
// - High range tap equals eight plus level of 32
// - Sixteen levels; source zero grounds ladder bottom
// - Disabled, low range, level zero clamps to ground
// - Pin output bit drives pin, disables digital buffers
// - Port read of reference pin returns zero
// - Sleep wake leaves ladder control unchanged
// - Reset clears ladder enable, fixed enable, pin output
// - Reset clears range and level fields
// - Fixed enable bit powers the fixed reference
// - Oscillator, detector, brownout, converter force fixed on
// - Stable flag sets after settling time elapses
// - Source bit picks external pins or supply span
// - Comparator bit picks external pin or internal reference
package crc_pkg;
    localparam logic [11:0] OFF_MIRROR_REFSEL = 12'h000;
    localparam logic [11:0] OFF_LADDER_CTRL   = 12'h004;
    localparam logic [11:0] OFF_FIXED_CTRL    = 12'h008;
    localparam logic [11:0] OFF_CMP_INPUT_SEL = 12'h00C;

    localparam int BIT_CMP_ONE_MIRROR = 7;
    localparam int BIT_CMP_TWO_MIRROR = 6;
    localparam int BIT_CMP_ONE_RSEL   = 5;
    localparam int BIT_CMP_TWO_RSEL   = 4;
    localparam int BIT_LADDER_EN      = 7;
    localparam int BIT_LADDER_OE      = 6;
    localparam int BIT_LADDER_RANGE   = 5;
    localparam int BIT_LADDER_SRC     = 4;
    localparam int BIT_FIXED_EN       = 7;
    localparam int BIT_FIXED_STABLE   = 6;
    localparam int BIT_NONINV_ONE     = 0;
    localparam int BIT_NONINV_TWO     = 1;

    localparam logic [7:0] RST_MIRROR_REFSEL = 8'h00;
    localparam logic [7:0] RST_LADDER_CTRL   = 8'h00;
    localparam logic [7:0] RST_FIXED_CTRL    = 8'h00;
    localparam logic [1:0] RST_CMP_INPUT_SEL = 2'h0;

    localparam logic [4:0] LOW_RANGE_STEPS   = 5'h18;
    localparam logic [5:0] HIGH_RANGE_STEPS  = 6'h20;
    localparam logic [4:0] HIGH_RANGE_OFFSET = 5'h08;

    localparam int CLK_PERIOD_NS      = 25;
    localparam int FIXED_SETTLE_US    = 25;
    localparam int FIXED_SETTLE_CYC   = (FIXED_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: test/crc_ctrl_properties.sv */
// Assertion checker for the comparator reference control block
module crc_chk (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       fast_internal_oscillator,
    input wire logic       voltage_detector,
    input wire logic       brownout_reset,
    input wire logic       adc_fixed_ref_chan,
    input wire logic       ref_pin_tris,
    input wire logic       ladder_power,
    input wire logic [4:0] ladder_tap,
    input wire logic       ladder_low_range,
    input wire logic       ladder_pin_output_enable,
    input wire logic       ref_pin_digital_out_en,
    input wire logic       ref_pin_digital_in_en,
    input wire logic       ref_pin_port_read,
    input wire logic       fixed_ref_power
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Tap decode ranges
    chk_tap_low_range: assert property (ladder_low_range |-> ladder_tap <= 5'h0F)
        else $error("low range tap out of span");
    chk_tap_high_range: assert property (
        !ladder_low_range |-> ladder_tap >= 5'h08 && ladder_tap <= 5'h17)
        else $error("high range tap out of span");
    // Pin override
    chk_pin_buffers_off: assert property (
        ladder_pin_output_enable |-> !ref_pin_digital_out_en && !ref_pin_digital_in_en)
        else $error("digital buffers on during reference output");
    chk_pin_port_dir: assert property (
        !ladder_pin_output_enable |-> ref_pin_digital_out_en == !ref_pin_tris)
        else $error("port direction not honoured");
    chk_pin_read_zero: assert property (ladder_pin_output_enable |-> !ref_pin_port_read)
        else $error("pin read not zero");
    chk_fixed_forced_on: assert property (
        (fast_internal_oscillator || voltage_detector || brownout_reset || adc_fixed_ref_chan)
        |-> fixed_ref_power)
        else $error("fixed reference not forced on");
    // Bus timing: slots fill at the taking edge, response one edge later
    chk_write_resp_next: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_resp_after_both: assert property (
        $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("response without both slots held");
    chk_power_on_write: assert property ($changed(ladder_power) |-> $rose(s_axi_bvalid))
        else $error("divider power moved without write");
    chk_reset_clears_all: assert property (
        $past(!aresetn) |-> !ladder_power && !ladder_pin_output_enable && !ladder_low_range
        && ladder_tap == 5'h08)
        else $error("reset left ladder state");
    cov_pin_out: cover property (ladder_pin_output_enable);
    cov_low_range: cover property (ladder_low_range && ladder_power);
    cov_forced: cover property (brownout_reset && fixed_ref_power);
endmodule

bind crc_ctrl crc_chk u_chk (.*);

/* File: test/crc_ctrl_tb_top.sv */
// Self-checking bench for the comparator reference control block
module crc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import crc_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, cmp_one_result = 0, cmp_two_result = 0;
    logic ref_pin_port_in = 1, ref_pin_tris = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, ladder_power, ladder_low_range, ladder_source_sel;
    logic ladder_bottom_ground, ladder_pin_output_enable, ref_pin_digital_out_en, ref_pin_digital_in_en;
    logic ref_pin_port_read, fixed_ref_power, cmp_one_internal_ref_sel, cmp_two_internal_ref_sel;
    logic cmp_one_noninv_internal, cmp_two_noninv_internal;
    logic fast_internal_oscillator, voltage_detector, brownout_reset, adc_fixed_ref_chan;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, q;
    logic [3:0]  s_axi_wstrb = 0, frc = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [4:0]  ladder_tap;
    logic [7:0]  cor [3] = '{8'h20, 8'h8F, 8'hDF};
    int          bad_count = 0, check_count = 0;
    assign {fast_internal_oscillator, voltage_detector, brownout_reset, adc_fixed_ref_chan} = frc;
    crc_ctrl #(.SETTLE_CYCLES(4)) u_dut (.*);
    initial begin forever #12.5 aclk = ~aclk; end
    // Expected tap for a ladder control byte
    function automatic logic [31:0] exp_tap(logic [31:0] v);
        return v[5] ? {28'h0, v[3:0]} : 32'h8 + v[3:0];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Bus write, address and data offered together
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {ta, tw, tb, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
        end while (!tb);
        s_axi_bready <= 0;
    endtask
    // Bus read
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ta, tr;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(negedge aclk);
            {ta, tr, v, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
        end while (!tr);
        s_axi_rready <= 0;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(25 * 20000);
        bad_count++;
        end_of_test;
    end
    initial begin
        void'($urandom(99405));
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        // Reset values
        for (int a = 0; a < 16; a += 4) begin
            rd(12'(a), q, rs);
            chk(q, 32'h0);
        end
        $display("test reset done");
        // Corner and random ladder settings
        for (int i = 0; i < 15; i++) begin
            d = (i < 3) ? {24'h0, cor[i]} : $urandom & 32'hFF;
            ref_pin_tris <= 1'($urandom);
            ref_pin_port_in <= 1'($urandom);
            wr(OFF_LADDER_CTRL, d, 4'hF, rs);
            chk(rs, RESP_OKAY);
            rd(OFF_LADDER_CTRL, q, rs);
            chk(q, d);
            chk(ladder_tap, exp_tap(d));
            chk({ladder_power, ladder_low_range, ladder_bottom_ground}, {d[7], d[5], !d[4]});
            chk(ladder_source_sel, d[4]);
            chk(ref_pin_digital_out_en, !d[6] & !ref_pin_tris);
            chk({ladder_pin_output_enable, ref_pin_digital_in_en}, {d[6], !d[6]});
            chk(ref_pin_port_read, !d[6] & ref_pin_port_in);
        end
        $display("test ladder done");
        // Mirror bits and reference selects
        for (int k = 0; k < 2; k++) begin
            cmp_one_result <= (k == 0);
            cmp_two_result <= (k == 1);
            wr(OFF_MIRROR_REFSEL, (k == 0) ? 32'hFF : 32'h1F, 4'hF, rs);
            rd(OFF_MIRROR_REFSEL, q, rs);
            chk(q, (k == 0) ? 32'hB0 : 32'h50);
            chk({cmp_one_internal_ref_sel, cmp_two_internal_ref_sel}, (k == 0) ? 2'h3 : 2'h1);
        end
        wr(OFF_CMP_INPUT_SEL, 32'h2, 4'hF, rs);
        chk({cmp_one_noninv_internal, cmp_two_noninv_internal}, 2'h1);
        $display("test mirror done");
        // Fixed reference enable, settle flag and forcing inputs
        wr(OFF_FIXED_CTRL, 32'hFF, 4'hF, rs);
        chk(fixed_ref_power, 1'b1);
        rd(OFF_FIXED_CTRL, q, rs);
        chk(q, 32'h80);
        repeat (8) @(posedge aclk);
        rd(OFF_FIXED_CTRL, q, rs);
        chk(q, 32'hC0);
        wr(OFF_FIXED_CTRL, 32'h0, 4'hF, rs);
        rd(OFF_FIXED_CTRL, q, rs);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            frc <= 4'h1 << i;
            @(negedge aclk);
            chk(fixed_ref_power, 1'b1);
        end
        @(posedge aclk);
        frc <= 4'h0;
        @(negedge aclk);
        chk(fixed_ref_power, 1'b0);
        $display("test fixed done");
        // Refusals and mid-run reset
        wr(12'h010, 32'hFF, 4'hF, rs);
        chk(rs, RESP_SLVERR);
        rd(12'h010, q, rs);
        chk(rs, RESP_SLVERR);
        chk(q, 32'h0);
        wr(OFF_LADDER_CTRL, 32'h55, 4'h0, rs);
        rd(OFF_LADDER_CTRL, q, rs);
        chk(q, d);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(OFF_LADDER_CTRL, q, rs);
        chk(q, 32'h0);
        $display("test refuse done");
        end_of_test;
    end
endmodule
